// file: dcg_pkg.sv
// Package of the debug command gate: command codes, reply constants and layout.
// Assumes one system clock; no registers reachable by software.
package dcg_pkg;
    localparam logic [7:0] CMD_READ_REVISION = 8'h00;
    localparam logic [7:0] CMD_READ_STATUS = 8'h02;
    localparam logic [7:0] CMD_READ_RUNTIME = 8'h03;
    localparam logic [7:0] CMD_WRITE_PC = 8'h06;
    localparam logic [7:0] CMD_READ_PC = 8'h07;
    localparam logic [7:0] CMD_WRITE_REG = 8'h08;
    localparam logic [7:0] CMD_READ_REG = 8'h09;
    localparam logic [7:0] CMD_WRITE_PROG = 8'h0A;
    localparam logic [7:0] CMD_READ_PROG = 8'h0B;
    localparam logic [7:0] CMD_WRITE_DATA = 8'h0C;
    localparam logic [7:0] CMD_READ_DATA = 8'h0D;
    localparam logic [7:0] CMD_READ_CRC = 8'h0E;
    localparam logic [7:0] CMD_RESERVED_0F = 8'h0F;
    localparam logic [7:0] CMD_STEP = 8'h10;
    localparam logic [7:0] CMD_STUFF = 8'h11;
    localparam logic [7:0] CMD_EXECUTE = 8'h12;
    localparam logic [7:0] CMD_FIRST_RESERVED = 8'h13;
    // Revision value is arbitrary.
    localparam logic [15:0] REVISION_WORD = 16'h0100;
    localparam logic [15:0] RUNTIME_RESET = 16'h0000;
    localparam logic [15:0] RUNTIME_MAX = 16'hFFFF;
    // Flash control register address (12-bit register space) and mass erase value.
    localparam logic [11:0] FLASH_CTRL_ADDR = 12'hFF8;
    localparam logic [11:0] FLASH_REG_FIRST = 12'hFF8;
    localparam logic [11:0] FLASH_REG_LAST = 12'hFFF;
    localparam logic [7:0] FLASH_MASS_ERASE = 8'h63;
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_REPLY = 5'b00010,
        ST_ADDR_HI = 5'b00100,
        ST_ADDR_LO = 5'b01000,
        ST_WDATA = 5'b10000
    } dcg_state_t;
endpackage

// file: dcg_runtime_counter.sv
// Runtime counter: counts system clock cycles with run high between breakpoints, saturating.
// Assumes run and clear come from logic on the same clock.
`timescale 1ns/1ns
module dcg_runtime_counter (
    input wire logic clk,
    input wire logic resetn,
    input wire logic run,
    input wire logic clear,
    output logic [15:0] count
);
    import dcg_pkg::*;

    logic [15:0] count_reg;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            count_reg <= RUNTIME_RESET;
        end else if (clear) begin
            count_reg <= RUNTIME_RESET;
        end else if (run && count_reg != RUNTIME_MAX) begin
            count_reg <= count_reg + 16'h0001;
        end
    end

    assign count = count_reg;
endmodule

// file: dcg_debug_command_gate.sv
// Command interpreter of the on-chip debugger with read-protect gating.
// Assumes command and data bytes arrive as one-cycle strobes from the serial
// link logic on the same clock, and reply bytes are taken under ready.
//
// How it works
// - Host sends command byte, then data; replies follow.
// - Command 00H returns revision, major byte first.
// - Command 02H returns one debugger status byte.
// - Runtime counter increments each clock the CPU runs between breakpoints.
// - Runtime counter starts at zero and saturates.
// - PC write and read refused under protection.
// - Protected register writes only reach flash registers.
// - Protected flash control write only mass erase.
// - Register read, program write/read disabled when protected.
// - Data write disabled protected; data read allowed.
// - Checksum read stays usable when protected.
// - Step, stuff, execute disabled under protection.
`timescale 1ns/1ns
module dcg_debug_command_gate (
    input wire logic clk,
    input wire logic resetn,
    input wire logic rx_valid,
    input wire logic [7:0] rx_byte,
    output logic tx_valid,
    output logic [7:0] tx_byte,
    input wire logic tx_ready,
    input wire logic read_protect,
    input wire logic [7:0] debugger_status_byte,
    input wire logic cpu_running,
    input wire logic breakpoint_hit,
    output logic cmd_valid,
    output logic [7:0] cmd_code,
    output logic [11:0] cmd_addr,
    output logic [7:0] cmd_data,
    output logic cmd_refused
);
    import dcg_pkg::*;

    dcg_state_t state_reg;
    logic [7:0] cmd_reg;
    logic [15:0] reply_reg;
    logic reply_two_reg;
    logic [11:0] addr_reg;
    logic [15:0] runtime;
    logic rp_meta_reg;
    logic rp_sync_reg;

    // Returns one when the command is blocked outright by read protection.
    function automatic logic blocked(input logic [7:0] code);
        case (code)
            CMD_WRITE_PC: blocked = 1'b1;
            CMD_READ_PC: blocked = 1'b1;
            CMD_READ_REG: blocked = 1'b1;
            CMD_WRITE_PROG: blocked = 1'b1;
            CMD_READ_PROG: blocked = 1'b1;
            CMD_WRITE_DATA: blocked = 1'b1;
            CMD_STEP: blocked = 1'b1;
            CMD_STUFF: blocked = 1'b1;
            CMD_EXECUTE: blocked = 1'b1;
            default: blocked = 1'b0;
        endcase
    endfunction

    // Returns one for reserved command codes.
    function automatic logic reserved(input logic [7:0] code);
        case (code)
            8'h01: reserved = 1'b1;
            8'h04: reserved = 1'b1;
            8'h05: reserved = 1'b1;
            CMD_RESERVED_0F: reserved = 1'b1;
            default: reserved = (code >= CMD_FIRST_RESERVED);
        endcase
    endfunction

    // Returns one for commands answered by this block with reply bytes.
    function automatic logic replies(input logic [7:0] code);
        replies = (code == CMD_READ_REVISION) || (code == CMD_READ_STATUS)
            || (code == CMD_READ_RUNTIME);
    endfunction

    // Returns one for single-byte commands passed on to the debug engine.
    function automatic logic engine_cmd(input logic [7:0] code);
        engine_cmd = !reserved(code) && !replies(code) && (code != CMD_WRITE_REG);
    endfunction

    // Read-protect option is a pin level; it passes two flip-flops.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rp_meta_reg <= 1'b0;
            rp_sync_reg <= 1'b0;
        end else begin
            rp_meta_reg <= read_protect;
            rp_sync_reg <= rp_meta_reg;
        end
    end

    dcg_runtime_counter u_runtime (
        .clk(clk),
        .resetn(resetn),
        .run(cpu_running),
        .clear(breakpoint_hit),
        .count(runtime)
    );

    // Command sequencer: walks the byte order of each command.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= ST_IDLE;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (rx_valid && replies(rx_byte)) begin
                        state_reg <= ST_REPLY;
                    end else if (rx_valid && rx_byte == CMD_WRITE_REG) begin
                        state_reg <= ST_ADDR_HI;
                    end
                end
                ST_REPLY: begin
                    if (tx_ready && !reply_two_reg) begin
                        state_reg <= ST_IDLE;
                    end
                end
                ST_ADDR_HI: begin
                    if (rx_valid) begin
                        state_reg <= ST_ADDR_LO;
                    end
                end
                ST_ADDR_LO: begin
                    if (rx_valid) begin
                        state_reg <= ST_WDATA;
                    end
                end
                ST_WDATA: begin
                    if (rx_valid) begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // Reply bytes are loaded at the command edge and leave high byte first.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            reply_reg <= 16'h0000;
            reply_two_reg <= 1'b0;
        end else if (state_reg == ST_IDLE && rx_valid) begin
            if (rx_byte == CMD_READ_REVISION) begin
                reply_reg <= REVISION_WORD;
                reply_two_reg <= 1'b1;
            end else if (rx_byte == CMD_READ_STATUS) begin
                reply_reg <= {debugger_status_byte, 8'h00};
                reply_two_reg <= 1'b0;
            end else if (rx_byte == CMD_READ_RUNTIME) begin
                reply_reg <= runtime;
                reply_two_reg <= 1'b1;
            end
        end else if (state_reg == ST_REPLY && tx_ready) begin
            reply_reg <= {reply_reg[7:0], 8'h00};
            reply_two_reg <= 1'b0;
        end
    end

    // Command byte and register address of a register write.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cmd_reg <= 8'h00;
            addr_reg <= 12'h000;
        end else if (state_reg == ST_IDLE && rx_valid) begin
            cmd_reg <= rx_byte;
        end else if (state_reg == ST_ADDR_HI && rx_valid) begin
            addr_reg <= {rx_byte[3:0], 8'h00};
        end else if (state_reg == ST_ADDR_LO && rx_valid) begin
            addr_reg <= {addr_reg[11:8], rx_byte};
        end
    end

    // Command, address and data handed to the debug engine.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cmd_code <= 8'h00;
            cmd_addr <= 12'h000;
            cmd_data <= 8'h00;
        end else if (state_reg == ST_IDLE && rx_valid && engine_cmd(rx_byte)) begin
            cmd_code <= rx_byte;
        end else if (state_reg == ST_WDATA && rx_valid) begin
            cmd_code <= cmd_reg;
            cmd_addr <= addr_reg;
            cmd_data <= rx_byte;
        end
    end

    // Accept and refuse pulses, gated by read protection.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cmd_valid <= 1'b0;
            cmd_refused <= 1'b0;
        end else begin
            cmd_valid <= 1'b0;
            cmd_refused <= 1'b0;
            if (state_reg == ST_IDLE && rx_valid && engine_cmd(rx_byte)) begin
                if (rp_sync_reg && blocked(rx_byte)) begin
                    cmd_refused <= 1'b1;
                end else begin
                    cmd_valid <= 1'b1;
                end
            end else if (state_reg == ST_WDATA && rx_valid) begin
                if (rp_sync_reg && (addr_reg < FLASH_REG_FIRST)) begin
                    cmd_refused <= 1'b1;
                end else if (rp_sync_reg && addr_reg == FLASH_CTRL_ADDR
                    && rx_byte != FLASH_MASS_ERASE) begin
                    cmd_refused <= 1'b1;
                end else begin
                    cmd_valid <= 1'b1;
                end
            end
        end
    end

    assign tx_valid = (state_reg == ST_REPLY);
    assign tx_byte = reply_reg[15:8];
endmodule

// file: dcg_props.sv
// Checker of the debug command gate: replies, gating and runtime count.
// Assumes the host keeps to the byte order of each command.
`timescale 1ns/1ns
module dcg_props
import dcg_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic rx_valid,
    input wire logic [7:0] rx_byte,
    input wire logic tx_valid,
    input wire logic [7:0] tx_byte,
    input wire logic tx_ready,
    input wire logic read_protect,
    input wire logic [7:0] debugger_status_byte,
    input wire logic cpu_running,
    input wire logic breakpoint_hit,
    input wire logic cmd_valid,
    input wire logic cmd_refused
);
    logic [1:0] rem;
    logic [2:0] rp;
    logic [15:0] cnt, cap;
    logic [11:0] adr;
    logic [7:0] last;
    logic first;
    wire idle = rx_valid && rem == 2'h0 && !tx_valid;
    wire on = read_protect && &rp;
    wire ok = adr >= FLASH_REG_FIRST && (adr != FLASH_CTRL_ADDR || rx_byte == FLASH_MASS_ERASE);
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt <= RUNTIME_RESET;
        end else if (breakpoint_hit) begin
            cnt <= RUNTIME_RESET;
        end else if (cpu_running && cnt != RUNTIME_MAX) begin
            cnt <= cnt + 16'h1;
        end
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            {rem, rp, cap, adr, last, first} <= '0;
        end else begin
            rp <= {rp[1:0], read_protect};
            if (idle) begin
                rem <= rx_byte == CMD_WRITE_REG ? 2'h3 : 2'h0;
                cap <= cnt;
                last <= rx_byte;
                first <= 1'b1;
            end else if (rx_valid && rem != 2'h0) begin
                rem <= rem - 2'h1;
                if (rem == 2'h3) begin
                    adr[11:8] <= rx_byte[3:0];
                end else if (rem == 2'h2) begin
                    adr[7:0] <= rx_byte;
                end
            end else if (tx_valid && tx_ready) begin
                first <= 1'b0;
            end
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence s_cmd(logic [7:0] c);
        idle && rx_byte == c;
    endsequence
    sequence s_take(logic [7:0] c);
        tx_valid && tx_ready && first && last == c;
    endsequence
    AST_REV_HI: assert property (s_cmd(CMD_READ_REVISION) |=>
        tx_valid && tx_byte == REVISION_WORD[15:8]) else $error("revision high byte");
    AST_REV_LO: assert property (s_take(CMD_READ_REVISION) |=>
        tx_valid && tx_byte == REVISION_WORD[7:0]) else $error("revision low byte");
    AST_STAT: assert property (s_cmd(CMD_READ_STATUS) |=> tx_valid &&
        tx_byte == $past(debugger_status_byte)) else $error("status byte");
    AST_STAT_ONE: assert property (s_take(CMD_READ_STATUS) |=> !tx_valid)
        else $error("status reply too long");
    AST_RUN: assert property (s_cmd(CMD_READ_RUNTIME) |=>
        tx_valid && tx_byte == cap[15:8]) else $error("runtime high byte");
    AST_RUN_LO: assert property (s_take(CMD_READ_RUNTIME) |=>
        tx_valid && tx_byte == cap[7:0]) else $error("runtime low byte");
    AST_BLOCK: assert property (idle && on && rx_byte inside {8'h06, 8'h07,
        [8'h09:8'h0C], [8'h10:8'h12]} |=> cmd_refused && !cmd_valid) else $error("not refused");
    AST_ALLOW: assert property (idle && on && rx_byte inside {8'h0D, 8'h0E} |=>
        cmd_valid && !cmd_refused) else $error("not accepted");
    AST_FLASH: assert property (rx_valid && rem == 2'h1 && on |=>
        cmd_valid == $past(ok) && cmd_refused == !$past(ok)) else $error("register write gate");
    AST_RSV: assert property (idle && !(rx_byte inside {8'h00, 8'h02, 8'h03,
        [8'h06:8'h0E], [8'h10:8'h12]}) |=> (!tx_valid && !cmd_valid && !cmd_refused)[*2])
        else $error("reserved code answered");
    AST_HOLD: assert property (tx_valid && !tx_ready |=>
        tx_valid && $stable(tx_byte)) else $error("reply byte dropped");
endmodule
bind dcg_debug_command_gate dcg_props props (
    .clk(clk),
    .resetn(resetn),
    .rx_valid(rx_valid),
    .rx_byte(rx_byte),
    .tx_valid(tx_valid),
    .tx_byte(tx_byte),
    .tx_ready(tx_ready),
    .read_protect(read_protect),
    .debugger_status_byte(debugger_status_byte),
    .cpu_running(cpu_running),
    .breakpoint_hit(breakpoint_hit),
    .cmd_valid(cmd_valid),
    .cmd_refused(cmd_refused)
);

// file: dcg_host.sv
// Host reply side of the debug link: takes reply bytes, optionally stalling.
// Assumes replies arrive under a valid and ready handshake on clk.
`timescale 1ns/1ns
module dcg_host (
    input wire logic clk,
    input wire logic resetn,
    input wire logic slow,
    input wire logic tx_valid,
    input wire logic [7:0] tx_byte,
    output logic tx_ready,
    output logic got,
    output logic [7:0] got_byte
);
    logic [1:0] pace;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pace <= 2'h0;
        end else begin
            pace <= pace + 2'h1;
        end
    end
    // A slow host is ready one cycle in four.
    assign tx_ready = !slow || pace == 2'h3;
    assign got = tx_valid && tx_ready;
    assign got_byte = tx_byte;
endmodule

// file: debug_command_gate_bench.sv
// Bench of the debug command gate: random and corner traffic, self-checked.
// Assumes the host model takes reply bytes.
`timescale 1ns/1ns
module debug_command_gate_bench;
    import dcg_pkg::*;
    logic clk = 0, resetn = 0, rx_valid = 0, read_protect = 0;
    logic cpu_running = 0, breakpoint_hit = 0, slow = 0;
    logic [7:0] rx_byte = 8'h00, debugger_status_byte = 8'h00;
    logic tx_valid, tx_ready, cmd_valid, cmd_refused, got;
    logic [7:0] tx_byte, cmd_code, cmd_data, got_byte;
    logic [11:0] cmd_addr;
    logic [31:0] rnd = 32'h09069335;
    int bad_count = 0, compares = 0;
    always #20 clk = ~clk;
    dcg_debug_command_gate dut (
        .clk(clk),
        .resetn(resetn),
        .rx_valid(rx_valid),
        .rx_byte(rx_byte),
        .tx_valid(tx_valid),
        .tx_byte(tx_byte),
        .tx_ready(tx_ready),
        .read_protect(read_protect),
        .debugger_status_byte(debugger_status_byte),
        .cpu_running(cpu_running),
        .breakpoint_hit(breakpoint_hit),
        .cmd_valid(cmd_valid),
        .cmd_code(cmd_code),
        .cmd_addr(cmd_addr),
        .cmd_data(cmd_data),
        .cmd_refused(cmd_refused)
    );
    dcg_host host (
        .clk(clk),
        .resetn(resetn),
        .slow(slow),
        .tx_valid(tx_valid),
        .tx_byte(tx_byte),
        .tx_ready(tx_ready),
        .got(got),
        .got_byte(got_byte)
    );
    function automatic logic [31:0] step(logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function automatic logic wok(logic [11:0] a, logic [7:0] d, logic p);
        return !p || (a >= FLASH_REG_FIRST && (a != FLASH_CTRL_ADDR || d == FLASH_MASS_ERASE));
    endfunction
    task automatic close_out();
        if (bad_count == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(logic [15:0] g, logic [15:0] e);
        compares++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic send(logic [7:0] b);
        @(negedge clk);
        rx_valid = 1'b1;
        rx_byte = b;
        @(negedge clk);
        rx_valid = 1'b0;
    endtask
    task automatic take(logic [7:0] e);
        int n;
        for (n = 0; got !== 1'b1 && n < 50; n++) @(negedge clk);
        if (n == 50) begin
            bad_count++;
            close_out();
        end
        chk(got_byte, e);
        @(negedge clk);
    endtask
    task automatic rt(int cyc);
        breakpoint_hit = 1'b1;
        @(negedge clk);
        breakpoint_hit = 1'b0;
        cpu_running = 1'b1;
        repeat (cyc) @(negedge clk);
        cpu_running = 1'b0;
        send(CMD_READ_RUNTIME);
        take(cyc > 65535 ? 8'hFF : 8'(cyc >> 8));
        take(cyc > 65535 ? 8'hFF : 8'(cyc));
    endtask
    initial begin
        logic [11:0] a;
        logic [7:0] d;
        logic [1:0] x;
        logic [7:0] rsv [7] = '{8'h01, 8'h04, 8'h05, 8'h0F, 8'h13, 8'hFF, 8'h80};
        repeat (16) @(negedge clk);
        resetn = 1'b1;
        slow = 1'b1;
        send(CMD_READ_REVISION);
        take(REVISION_WORD[15:8]);
        take(REVISION_WORD[7:0]);
        rnd = step(rnd);
        debugger_status_byte = rnd[7:0];
        send(CMD_READ_STATUS);
        take(rnd[7:0]);
        slow = 1'b0;
        rt(int'(rnd[15:8]) + 1);
        rt(66000);
        for (int p = 0; p < 2; p++) begin
            read_protect = p[0];
            repeat (3) @(negedge clk);
            for (int c = 6; c <= 18; c++) begin
                if (c != 8 && c != 15) begin
                    send(8'(c));
                    x = (p == 1 && c != 13 && c != 14) ? 2'b01 : 2'b10;
                    chk({cmd_valid, cmd_refused}, x);
                    chk(cmd_code, 8'(c));
                end
            end
            for (int k = 0; k < 4; k++) begin
                rnd = step(rnd);
                d = rnd[7:0];
                if (k == 0 || d == FLASH_MASS_ERASE) begin
                    d = FLASH_MASS_ERASE ^ 8'(k != 0);
                end
                a = (k < 2) ? FLASH_CTRL_ADDR : (k == 2) ? {1'b0, rnd[18:8]} : FLASH_REG_LAST;
                send(CMD_WRITE_REG);
                send({4'h0, a[11:8]});
                send(a[7:0]);
                send(d);
                chk({cmd_valid, cmd_refused}, {wok(a, d, p[0]), !wok(a, d, p[0])});
                chk(cmd_code, CMD_WRITE_REG);
                chk(cmd_addr, a);
                chk(cmd_data, d);
            end
        end
        rsv[6] = 8'h80 | rnd[7:0];
        foreach (rsv[i]) begin
            send(rsv[i]);
            repeat (3) begin
                chk({tx_valid, cmd_valid, cmd_refused}, 3'b000);
                chk(cmd_code, CMD_WRITE_REG);
                @(negedge clk);
            end
        end
        close_out();
    end
endmodule
